// >>> shared/hsp_pkg.sv
// shared constants and types for the hub strap and sideband pin block
`default_nettype none
package hsp_pkg;
   localparam int NUM_PORTS = 3;
   localparam int SYNC_STAGES = 3;
   localparam int CLK_HZ = 100_000_000;
   localparam int SLOW_HZ = 30_000_000;
   localparam int FAST_HZ = 60_000_000;
   // half period in cycles, rounded down, at least one
   localparam int SLOW_HALF_RAW = CLK_HZ / (2 * SLOW_HZ);
   localparam int FAST_HALF_RAW = CLK_HZ / (2 * FAST_HZ);
   localparam int SLOW_HALF = (SLOW_HALF_RAW < 1) ? 1 : SLOW_HALF_RAW;
   localparam int FAST_HALF = (FAST_HALF_RAW < 1) ? 1 : FAST_HALF_RAW;
   localparam int DIV_W = 4;
   localparam logic [DIV_W-1:0] SLOW_HALF_CNT = DIV_W'(SLOW_HALF);
   localparam logic [DIV_W-1:0] FAST_HALF_CNT = DIV_W'(FAST_HALF);
   localparam logic [DIV_W-1:0] DIV_ZERO = 4'h0;
   localparam logic LINE_ENABLED = 1'b0;
   localparam logic LINE_DISABLED = 1'b1;
   localparam logic RATE_SLOW = 1'b0;
   localparam logic RATE_FAST = 1'b1;

   typedef enum logic [1:0] {
      HSP_RESET = 2'b00,
      HSP_LATCH = 2'b01,
      HSP_RUN = 2'b11
   } hsp_state_t;

   // per-port pair of line disable straps, plus then minus
   typedef struct packed {
      logic plusLine;
      logic minusLine;
   } hsp_strap_pair_t;

   typedef struct packed {
      logic out;
      logic oe;
   } hsp_pin_drive_t;
endpackage
`default_nettype wire

// >>> hdl/hsp_strap_sideband.sv
// strap capture and sideband pin control for downstream ports 2 to 4
// Notes on behaviour
// - a port is disabled only when both of its line straps latched high.
// - each latched line strap decodes 0 as line enabled, 1 as disabled.
// - port 3 plus-line strap pairs with its minus partner; 1 disables plus line.
// - flash chip enable is active low; low selects the target.
// - with flash enabled, chip enable is held high in every powerdown state.
// - rate strap latched at reset: 0 (30 MHz) and 1 (60 MHz) both give a one-cycle half period, so 50 MHz.
// - rate strap latched 1: the rate pin floats while the chip is suspended.
// - rate strap latched 0: the rate pin is driven low while suspended.
// - a low over-current sense on port 1 or 2 means over-current.
// - management clock is input only; data is open-drain both ways.
`default_nettype none
module hsp_strap_sideband
   import hsp_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire hsp_pkg::hsp_strap_pair_t [hsp_pkg::NUM_PORTS-1:0] portDisableStraps,
   input wire logic flashRateStrapIn,
   output hsp_pkg::hsp_pin_drive_t flashRatePin,
   input wire logic flashEnable,
   input wire logic powerdown,
   input wire logic suspend,
   input wire logic flashSelect,
   input wire logic flashDataOut,
   output logic flashChipEnable_n,
   output logic flashClock,
   output logic flashSerialOut,
   input wire logic flashSerialIn,
   output logic flashSerialInSample,
   output logic [hsp_pkg::NUM_PORTS-1:0] plusLineDisabled,
   output logic [hsp_pkg::NUM_PORTS-1:0] minusLineDisabled,
   output logic [hsp_pkg::NUM_PORTS-1:0] portDisabled,
   output logic flashRateFast,
   output logic strapsValid,
   input wire logic port1OvercurrentLow,
   input wire logic port2OvercurrentLow,
   output logic [1:0] overcurrent,
   input wire logic mgmtSerialClockIn,
   input wire logic mgmtSerialDataIn,
   input wire logic mgmtDataPullLow,
   output logic mgmtSerialClock,
   output logic mgmtSerialData,
   output hsp_pkg::hsp_pin_drive_t mgmtSerialDataDrive
);
   import hsp_pkg::*;

   hsp_state_t state_reg;
   hsp_state_t state_next;
   logic [NUM_PORTS-1:0] plus_reg;
   logic [NUM_PORTS-1:0] minus_reg;
   logic rate_reg;
   logic [SYNC_STAGES-1:0] ocs1Sync_reg;
   logic [SYNC_STAGES-1:0] ocs2Sync_reg;
   logic [SYNC_STAGES-1:0] sclSync_reg;
   logic [SYNC_STAGES-1:0] sdaSync_reg;
   logic [SYNC_STAGES-1:0] misoSync_reg;
   logic [1:0] oc_reg;
   logic scl_reg;
   logic sda_reg;
   logic miso_reg;
   logic [DIV_W-1:0] div_reg;
   logic sck_reg;
   logic mosi_reg;
   logic ce_n_reg;
   wire latchNow;
   wire [DIV_W-1:0] halfCount;
   wire divTick;
   wire sckRise;
   wire ceHold;
   wire [DIV_W-1:0] divNext;
   wire rateDriveLow;
   wire sckSampleEn;

   always_comb begin
      case (state_reg)
         HSP_RESET: state_next = HSP_LATCH;
         HSP_LATCH: state_next = HSP_RUN;
         HSP_RUN: state_next = HSP_RUN;
         default: state_next = HSP_RESET;
      endcase
   end

   assign latchNow = (state_reg == HSP_LATCH);

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_reg <= HSP_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   genvar p;
   generate
      for (p = 0; p < NUM_PORTS; p++) begin : g_port
         always_ff @(posedge clk) begin
            if (!reset_n) begin
               plus_reg[p] <= LINE_ENABLED;
               minus_reg[p] <= LINE_ENABLED;
            end else if (latchNow) begin
               plus_reg[p] <= portDisableStraps[p].plusLine;
               minus_reg[p] <= portDisableStraps[p].minusLine;
            end
         end
         assign portDisabled[p] = (plus_reg[p] == LINE_DISABLED) &&
            (minus_reg[p] == LINE_DISABLED);
      end
   endgenerate

   assign plusLineDisabled = plus_reg;
   assign minusLineDisabled = minus_reg;
   assign strapsValid = (state_reg == HSP_RUN);

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rate_reg <= RATE_SLOW;
      end else if (latchNow) begin
         rate_reg <= flashRateStrapIn;
      end
   end
   assign flashRateFast = rate_reg;

   // drive low when slow and suspended
   assign rateDriveLow = strapsValid && suspend && (rate_reg == RATE_SLOW);
   assign flashRatePin = '{out: 1'b0,
      oe: rateDriveLow};

   // three-stage synchronisers, second and third must agree
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ocs1Sync_reg <= '1;
         ocs2Sync_reg <= '1;
         sclSync_reg <= '1;
         sdaSync_reg <= '1;
         misoSync_reg <= '0;
      end else begin
         ocs1Sync_reg <= {ocs1Sync_reg[SYNC_STAGES-2:0], port1OvercurrentLow};
         ocs2Sync_reg <= {ocs2Sync_reg[SYNC_STAGES-2:0], port2OvercurrentLow};
         sclSync_reg <= {sclSync_reg[SYNC_STAGES-2:0], mgmtSerialClockIn};
         sdaSync_reg <= {sdaSync_reg[SYNC_STAGES-2:0], mgmtSerialDataIn};
         misoSync_reg <= {misoSync_reg[SYNC_STAGES-2:0], flashSerialIn};
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         oc_reg <= 2'h0;
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
         miso_reg <= 1'b0;
      end else begin
         if (ocs1Sync_reg[1] == ocs1Sync_reg[2]) oc_reg[0] <= ~ocs1Sync_reg[2];
         if (ocs2Sync_reg[1] == ocs2Sync_reg[2]) oc_reg[1] <= ~ocs2Sync_reg[2];
         if (sclSync_reg[1] == sclSync_reg[2]) scl_reg <= sclSync_reg[2];
         if (sdaSync_reg[1] == sdaSync_reg[2]) sda_reg <= sdaSync_reg[2];
         if (misoSync_reg[1] == misoSync_reg[2]) miso_reg <= misoSync_reg[2];
      end
   end
   assign overcurrent = oc_reg;

   assign mgmtSerialClock = scl_reg;
   assign mgmtSerialData = sda_reg;
   assign mgmtSerialDataDrive = '{out: 1'b0,
      oe: mgmtDataPullLow};

   assign halfCount = (rate_reg == RATE_FAST) ? FAST_HALF_CNT : SLOW_HALF_CNT;
   assign divTick = (div_reg == (halfCount - 4'h1));
   assign divNext = divTick ? DIV_ZERO : (div_reg + 4'h1);
   assign sckRise = divTick && !sck_reg;
   assign ceHold = powerdown && flashEnable;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         div_reg <= DIV_ZERO;
         sck_reg <= 1'b0;
         mosi_reg <= 1'b0;
         ce_n_reg <= 1'b1;
      end else begin
         ce_n_reg <= ~(flashSelect && flashEnable && strapsValid && !ceHold);
         if (!ce_n_reg && !ceHold) begin
            div_reg <= divNext;
            if (divTick) sck_reg <= ~sck_reg;
            if (divTick && sck_reg) mosi_reg <= flashDataOut;
         end else begin
            div_reg <= DIV_ZERO;
            sck_reg <= 1'b0;
            mosi_reg <= flashDataOut;
         end
      end
   end

   assign flashChipEnable_n = ce_n_reg;
   assign flashClock = sck_reg;
   assign flashSerialOut = mosi_reg;

   assign sckSampleEn = sckRise && !ce_n_reg;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         flashSerialInSample <= 1'b0;
      end else if (sckSampleEn) begin
         flashSerialInSample <= miso_reg;
      end
   end
endmodule // hsp_strap_sideband
`default_nettype wire

// >>> testbench/hsp_strap_sideband_props.sv
// assertion checker for the strap and sideband block
`default_nettype none
module hsp_strap_sideband_props
   import hsp_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic strapsValid,
   input wire logic [hsp_pkg::NUM_PORTS-1:0] plusLineDisabled,
   input wire logic [hsp_pkg::NUM_PORTS-1:0] minusLineDisabled,
   input wire logic [hsp_pkg::NUM_PORTS-1:0] portDisabled,
   input wire logic flashRateFast,
   input wire logic flashEnable,
   input wire logic powerdown,
   input wire logic suspend,
   input wire logic flashSelect,
   input wire logic flashChipEnable_n,
   input wire hsp_pkg::hsp_pin_drive_t flashRatePin,
   input wire logic port1OvercurrentLow,
   input wire logic [1:0] overcurrent,
   input wire logic mgmtDataPullLow,
   input wire hsp_pkg::hsp_pin_drive_t mgmtSerialDataDrive
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   AST_PORT_DIS: assert property (strapsValid |->
      portDisabled == (plusLineDisabled & minusLineDisabled)) else $error("port disable wrong");
   AST_STRAP_HOLD: assert property (strapsValid && $past(strapsValid) |->
      $stable(plusLineDisabled) && $stable(flashRateFast)) else $error("strap changed");
   AST_CE_SELECT: assert property (flashSelect && flashEnable && strapsValid && !powerdown
      |=> !flashChipEnable_n) else $error("chip enable not low");
   AST_CE_POWERDOWN: assert property (flashEnable && powerdown |=> flashChipEnable_n)
      else $error("chip enable low in powerdown");
   AST_RATE_LOW: assert property (strapsValid && suspend && !flashRateFast |->
      flashRatePin.oe && !flashRatePin.out) else $error("rate pin not driven low");
   AST_RATE_FLOAT: assert property (!suspend || flashRateFast |-> !flashRatePin.oe)
      else $error("rate pin driven");
   AST_OVERCURRENT: assert property ((strapsValid && $stable(port1OvercurrentLow))[*5]
      |-> overcurrent[0] == !port1OvercurrentLow) else $error("overcurrent wrong");
   AST_MGMT_DRIVE: assert property (mgmtSerialDataDrive.oe == mgmtDataPullLow
      && !mgmtSerialDataDrive.out) else $error("data drive not open drain");
endmodule // hsp_strap_sideband_props
`default_nettype wire

// >>> testbench/hsp_board_model.sv
// board model: strap resistors and flash target
`default_nettype none
module hsp_board_model
   import hsp_pkg::*;
(
   input wire logic rateStrap,
   input wire hsp_pkg::hsp_pin_drive_t ratePinDrive,
   input wire logic flashChipEnable_n,
   output logic rateStrapPin,
   output logic flashSerialIn
);
   timeunit 1ns;
   timeprecision 1ps;
   assign rateStrapPin = ratePinDrive.oe ? ratePinDrive.out : rateStrap;
   // target answers ones, pull-down when deselected
   assign flashSerialIn = !flashChipEnable_n;
endmodule // hsp_board_model
`default_nettype wire

// >>> testbench/test_hsp_strap_sideband.sv
// self-checking bench for the strap and sideband block
`default_nettype none
module test_hsp_strap_sideband;
   timeunit 1ns;
   timeprecision 1ps;
   import hsp_pkg::*;
   logic clk = 0, reset_n = 0, rateStrap = 0, flashRateStrapIn, flashSerialIn;
   logic flashEnable = 0, powerdown = 0, suspend = 0, flashSelect = 0, flashDataOut = 0;
   logic port1OvercurrentLow = 1, port2OvercurrentLow = 1, mgmtDataPullLow = 0;
   logic mgmtSerialClockIn = 1, mgmtSerialDataIn = 1, flashChipEnable_n, flashClock;
   logic flashSerialOut, flashSerialInSample, flashRateFast, strapsValid, c;
   logic mgmtSerialClock, mgmtSerialData;
   logic [1:0] overcurrent;
   logic [NUM_PORTS-1:0] plusLineDisabled, minusLineDisabled, portDisabled;
   hsp_strap_pair_t [NUM_PORTS-1:0] portDisableStraps = '0;
   hsp_pin_drive_t flashRatePin, mgmtSerialDataDrive;
   int err_total = 0, samples_checked = 0, cycles = 0;
   always #5 clk = ~clk;
   hsp_strap_sideband i_dut(.clk, .reset_n, .portDisableStraps, .flashRateStrapIn,
      .flashRatePin, .flashEnable, .powerdown, .suspend, .flashSelect, .flashDataOut,
      .flashChipEnable_n, .flashClock, .flashSerialOut, .flashSerialIn, .flashSerialInSample,
      .plusLineDisabled, .minusLineDisabled, .portDisabled, .flashRateFast, .strapsValid,
      .port1OvercurrentLow, .port2OvercurrentLow, .overcurrent, .mgmtSerialClockIn,
      .mgmtSerialDataIn, .mgmtDataPullLow, .mgmtSerialClock, .mgmtSerialData,
      .mgmtSerialDataDrive);
   hsp_board_model i_board(.rateStrap, .ratePinDrive(flashRatePin), .flashChipEnable_n,
      .rateStrapPin(flashRateStrapIn), .flashSerialIn);
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic t_straps(input logic [5:0] p, input logic r);
      reset_n = 0;
      portDisableStraps = p;
      rateStrap = r;
      step(2);
      reset_n = 1;
      step(3);
      portDisableStraps = ~p;
      rateStrap = ~r;
      step(2);
      chk({plusLineDisabled, minusLineDisabled}, {p[5], p[3], p[1], p[4], p[2], p[0]});
      chk(portDisabled, {p[5] & p[4], p[3] & p[2], p[1] & p[0]});
      chk(plusLineDisabled[1], p[3]);
      chk(flashRateFast, r);
      rateStrap = 1;
      suspend = 1;
      step(1);
      chk(flashRatePin.oe, !r);
      chk(flashRateStrapIn, r);
      suspend = 0;
      step(1);
      chk(flashRatePin.oe, 1'h0);
   endtask
   task automatic t_flash;
      flashEnable = 1;
      flashSelect = 1;
      flashDataOut = 1;
      step(1);
      chk(flashChipEnable_n, 1'h0);
      chk(flashSerialOut, 1'h1);
      chk(flashSerialInSample, 1'h0);
      step(3);
      c = flashClock;
      step(1);
      chk(flashClock, !c);
      step(2);
      chk(flashSerialInSample, 1'h1);
      powerdown = 1;
      step(1);
      chk(flashChipEnable_n, 1'h1);
      {powerdown, flashSelect, flashDataOut, flashEnable} = '0;
   endtask
   task automatic t_sense;
      port1OvercurrentLow = 0;
      mgmtDataPullLow = 1;
      mgmtSerialClockIn = 0;
      mgmtSerialDataIn = 0;
      step(6);
      chk(overcurrent, 2'h1);
      chk({mgmtSerialDataDrive, mgmtSerialClock, mgmtSerialData}, 4'h4);
      {port1OvercurrentLow, port2OvercurrentLow} = 2'h2;
      step(6);
      chk(overcurrent, 2'h2);
      port2OvercurrentLow = 1;
      step(6);
      chk(overcurrent, 2'h0);
      port1OvercurrentLow = 0;
      step(1);
      port1OvercurrentLow = 1;
      step(6);
      chk(overcurrent, 2'h0);
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 500) begin
         err_total++;
         summarize();
      end
   end
   initial begin
      t_straps(6'h36, 1'h1);
      t_flash();
      t_straps(6'h0F, 1'h0);
      t_sense();
      summarize();
   end
endmodule // test_hsp_strap_sideband
bind hsp_strap_sideband hsp_strap_sideband_props i_props(.clk, .reset_n, .strapsValid,
   .plusLineDisabled, .minusLineDisabled, .portDisabled, .flashRateFast, .flashEnable,
   .powerdown, .suspend, .flashSelect, .flashChipEnable_n, .flashRatePin,
   .port1OvercurrentLow, .overcurrent, .mgmtDataPullLow, .mgmtSerialDataDrive);
`default_nettype wire
